// [inc/ss7_cfg_pkg.sv]
// Constants for the link configuration and protocol timer core.
// Assumes a single 100 MHz system clock and a 16-bit register port.
package ss7_cfg_pkg;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 16;
  localparam int NUM_TIMERS = 13;

  // Timing
  localparam int CLOCK_PERIOD_NS   = 10;
  localparam int SCALER_CLOCK_DIV  = 32;
  localparam int NARROW_MULT_SHIFT = 4;
  localparam int LOOP_CLOCK_DIV    = 8;
  localparam logic [16:0] NARROW_ZERO_PERIOD = 17'h01010;
  localparam logic [16:0] WIDE_FULL_PERIOD   = 17'h10000;
  localparam logic [7:0]  UNIT_WINDOW        = 8'h80;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_MODE        = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SCALE_WORD  = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_OCTET_LO    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TIMER_BASE  = 8'h06;
  localparam logic [ADDR_W-1:0] OFS_WIDE_SCALER = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_JAPAN_BASE  = 8'h90;
  localparam logic [ADDR_W-1:0] OFS_CONTROL     = 8'ha0;
  localparam logic [ADDR_W-1:0] OFS_STATUS      = 8'ha2;

  // Mode word fields, then the octet limit bits of the scale word
  localparam int MODE_EXT_CONTROL_FORCE = 10;
  localparam int MODE_EXT_ADDRESS_FORCE = 9;
  localparam int MODE_NO_EXTRACT        = 8;
  localparam int MODE_EXT_CONTROL_FIELD = 7;
  localparam int MODE_EXT_ADDRESS_FIELD = 6;
  localparam int MODE_RX_CHECK_DISABLE  = 5;
  localparam int MODE_TX_CHECK_DISABLE  = 4;
  localparam int MODE_CHECK_WIDTH_SEL   = 3;
  localparam int MODE_LOOP_LSB          = 0;
  localparam int OCTET_HI_LSB           = 8;
  localparam int OCTET_HI_MSB           = 14;

  localparam logic [2:0] LOOP_NORMAL       = 3'h0;
  localparam logic [2:0] LOOP_SIMPLE       = 3'h4;
  localparam logic [2:0] LOOP_CLOCKLESS    = 3'h5;
  localparam logic [2:0] LOOP_SILENT       = 3'h6;
  localparam logic [2:0] LOOP_SILENT_CLKLS = 3'h7;

  // Control word fields
  localparam int CTRL_WIDE_SCALER_EN = 0;
  localparam int CTRL_JAPAN_VARIANT  = 1;
  localparam int CTRL_TX_DEMAND      = 2;

  // Timer slots: aligned_ready, not_aligned, aligned, normal/emerg proving, busy repeat,
  // remote congest, ack wait, tx poll, then the four interval timers.
  localparam int TMR_BUSY_REPEAT = 5;
  localparam int TMR_TX_POLL     = 8;
  localparam int TMR_FIRST_JAPAN = 9;
  localparam logic [NUM_TIMERS-1:0] LINK_FAIL_MASK = 13'h00c7;
  localparam logic [NUM_TIMERS-1:0] PROVING_MASK   = 13'h0018;
  localparam logic [NUM_TIMERS-1:0] PERIODIC_MASK  = 13'h1f20;

  localparam logic [DATA_W-1:0] MODE_RESET  = 16'h0000;
  localparam logic [DATA_W-1:0] WORD_RESET  = 16'h0000;
endpackage

// [logic/ss7_link_config_timers.sv]
// Link configuration word decode and prescaled protocol timer bank.
// Assumes the protocol engine starts/stops timers on the same clock and
// software fills the parameter block over the plain register port.
// Notes on behaviour
// - Force plus extended address bits give two-octet addresses, first bit ignored.
// - No-extract mode: length and service octets land in buffer bytes one, two.
// - Receive check disabled: still strip 16/32 check bits, skip verification.
// - Transmit check disabled: append no check sequence, else append one.
// - Width bit one selects 16-bit check, zero selects 32-bit.
// - Loop 0 normal; loop 4 feeds transmit data and clock to receiver.
// - Loop 5 internal data, both clocks from system clock over eight.
// - Loop 6 is loop 4 with data pin ones; 7 is loop 5 with ones.
// - Low byte of the scale word is shared prescaler for protocol timers.
// - Prescaler steps every 32 clocks; at zero ticks timers and reloads.
// - Narrow prescaler times 16: one gives 512 clocks, zero 131584.
// - Wide scaler enable uses 16-bit word as prescaler, not multiplied.
// - Octet window limit output joins bits 14:8 with the low word.
// - Unit retransmission window fixed at 128.
// - Alignment timers signal link failure on expiry.
// - Proving timers set normal and emergency proving period lengths.
// - Busy indication repeats on busy timer while locally congested.
// - Remote congestion timer expiry signals link failure.
// - Acknowledge wait timer expiry signals link failure.
// - Transmit scan on demand, received unit or poll expiry.
// - Four interval timers pace repeat units, only with Japanese variant.
//
// The address-and-strobe port and the address map were chosen for this implementation.
module ss7_link_config_timers
  import ss7_cfg_pkg::*;
#(
  parameter int unsigned TICK_DIV = SCALER_CLOCK_DIV
) (
  input  wire logic                  I_CLOCK,
  input  wire logic                  I_RESET,
  input  wire logic [ADDR_W-1:0]     i_ADDR,
  input  wire logic [DATA_W-1:0]     i_WDATA,
  input  wire logic                  i_WRITE,
  input  wire logic                  i_READ,
  input  wire logic [NUM_TIMERS-1:0] i_TIMER_START,
  input  wire logic [NUM_TIMERS-1:0] i_TIMER_STOP,
  input  wire logic                  i_LOCAL_CONGESTED,
  input  wire logic                  i_UNIT_RECEIVED,
  output logic [DATA_W-1:0]          o_RDATA,
  output logic                       o_ADDR_TWO_OCTET,
  output logic                       o_LEN_IN_BUFFER,
  output logic                       o_RX_CHECK_STRIP,
  output logic                       o_RX_CHECK_VERIFY,
  output logic                       o_TX_CHECK_APPEND,
  output logic                       o_CHECK_WIDTH_16,
  output logic                       o_LOOP_INTERNAL,
  output logic                       o_LOOP_DIV_CLOCK,
  output logic                       o_TX_FORCE_ONES,
  output logic                       o_DIV8_CLK,
  output logic [22:0]                o_OCTET_WINDOW_LIMIT,
  output logic [7:0]                 o_UNIT_WINDOW_LIMIT,
  output logic [NUM_TIMERS-1:0]      o_TIMER_EXPIRED,
  output logic                       o_LINK_FAIL,
  output logic                       o_PROVING_DONE,
  output logic                       o_BUSY_REPEAT,
  output logic                       o_TX_SCAN,
  output logic [3:0]                 o_INTERVAL_SEND
);

  localparam int DIV_W = $clog2(TICK_DIV);

  if (TICK_DIV < 2 || (1 << DIV_W) != TICK_DIV) begin : g_bad_div
    $error("TICK_DIV must be a power of two of at least 2");
  end

  logic [DATA_W-1:0]     mode_word;
  logic [DATA_W-1:0]     scale_word;
  logic [DATA_W-1:0]     octet_lo;
  logic [DATA_W-1:0]     wide_scaler;
  logic [DATA_W-1:0]     period [NUM_TIMERS];
  logic                  wide_scaler_en;
  logic                  japan_variant_en;
  logic                  tx_demand;
  logic [NUM_TIMERS-1:0] expired_sticky;
  logic [NUM_TIMERS-1:0] exp_now;
  logic [DIV_W-1:0]      div_count;
  logic                  base_step;
  logic [16:0]           scale_count;
  logic [16:0]           scale_period;
  logic                  tick;
  logic [1:0]            loop_count;
  logic [2:0]            loopback_sel;
  logic                  write_timer;
  logic                  read_timer;
  logic [3:0]            timer_sel;
  logic                  timer_hit;

  assign loopback_sel = mode_word[MODE_LOOP_LSB +: 3];

  // Timer period word decode; two separate windows of the parameter block
  function automatic logic [4:0] decode_timer(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] rel;
    decode_timer = 5'h00;
    rel = '0;
    if (addr >= OFS_TIMER_BASE && addr < OFS_WIDE_SCALER && !addr[0]) begin
      rel = addr - OFS_TIMER_BASE;
      decode_timer = {1'b1, rel[4:1]};
    end else if (addr >= OFS_JAPAN_BASE && addr < OFS_CONTROL && !addr[0]) begin
      rel = addr - OFS_JAPAN_BASE;
      if (rel[ADDR_W-1:1] < 7'(NUM_TIMERS - TMR_FIRST_JAPAN)) begin
        decode_timer = {1'b1, 4'(rel[4:1] + 4'(TMR_FIRST_JAPAN))};
      end
    end
  endfunction

  assign {timer_hit, timer_sel} = decode_timer(i_ADDR);
  assign write_timer = i_WRITE && timer_hit;
  assign read_timer  = i_READ && timer_hit;

  // Configuration registers
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      mode_word        <= MODE_RESET;
      scale_word       <= WORD_RESET;
      octet_lo         <= WORD_RESET;
      wide_scaler      <= WORD_RESET;
      wide_scaler_en   <= 1'b0;
      japan_variant_en <= 1'b0;
    end else if (i_WRITE) begin
      case (i_ADDR)
        OFS_MODE:        mode_word <= i_WDATA;
        OFS_SCALE_WORD:  scale_word <= i_WDATA;
        OFS_OCTET_LO:    octet_lo <= i_WDATA;
        OFS_WIDE_SCALER: wide_scaler <= i_WDATA;
        OFS_CONTROL: begin
          wide_scaler_en   <= i_WDATA[CTRL_WIDE_SCALER_EN];
          japan_variant_en <= i_WDATA[CTRL_JAPAN_VARIANT];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        period[i] <= WORD_RESET;
      end
    end else if (write_timer) begin
      period[timer_sel] <= i_WDATA;
    end
  end

  // Demand is a one-cycle request, not a stored bit
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      tx_demand <= 1'b0;
    end else begin
      tx_demand <= i_WRITE && i_ADDR == OFS_CONTROL && i_WDATA[CTRL_TX_DEMAND];
    end
  end

  // Expiry status, write one to clear; a new expiry beats the clear
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      expired_sticky <= '0;
    end else if (i_WRITE && i_ADDR == OFS_STATUS) begin
      expired_sticky <= (expired_sticky & ~i_WDATA[NUM_TIMERS-1:0]) | exp_now;
    end else begin
      expired_sticky <= expired_sticky | exp_now;
    end
  end

  // Read port, data valid only in the cycle after the strobe
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      o_RDATA <= '0;
    end else if (read_timer) begin
      o_RDATA <= period[timer_sel];
    end else if (i_READ) begin
      case (i_ADDR)
        OFS_MODE:        o_RDATA <= mode_word;
        OFS_SCALE_WORD:  o_RDATA <= scale_word;
        OFS_OCTET_LO:    o_RDATA <= octet_lo;
        OFS_WIDE_SCALER: o_RDATA <= wide_scaler;
        OFS_CONTROL:     o_RDATA <= {14'h0000, japan_variant_en, wide_scaler_en};
        OFS_STATUS:      o_RDATA <= {3'h0, expired_sticky};
        default:         o_RDATA <= '0;
      endcase
    end else begin
      o_RDATA <= '0;
    end
  end

  // Framing options; control force bit is the host's to keep clear, unused here
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      o_ADDR_TWO_OCTET  <= 1'b0;
      o_LEN_IN_BUFFER   <= 1'b0;
      o_RX_CHECK_STRIP  <= 1'b0;
      o_RX_CHECK_VERIFY <= 1'b0;
      o_TX_CHECK_APPEND <= 1'b0;
      o_CHECK_WIDTH_16  <= 1'b0;
    end else begin
      o_ADDR_TWO_OCTET  <= mode_word[MODE_EXT_ADDRESS_FORCE] && mode_word[MODE_EXT_ADDRESS_FIELD];
      o_LEN_IN_BUFFER   <= mode_word[MODE_NO_EXTRACT];
      o_RX_CHECK_STRIP  <= 1'b1;
      o_RX_CHECK_VERIFY <= !mode_word[MODE_RX_CHECK_DISABLE];
      o_TX_CHECK_APPEND <= !mode_word[MODE_TX_CHECK_DISABLE];
      o_CHECK_WIDTH_16  <= mode_word[MODE_CHECK_WIDTH_SEL];
    end
  end

  // Loopback selection; codes 1 to 3 are undefined and run as normal
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      o_LOOP_INTERNAL  <= 1'b0;
      o_LOOP_DIV_CLOCK <= 1'b0;
      o_TX_FORCE_ONES  <= 1'b0;
    end else begin
      o_LOOP_INTERNAL  <= loopback_sel[2];
      o_LOOP_DIV_CLOCK <= loopback_sel == LOOP_CLOCKLESS || loopback_sel == LOOP_SILENT_CLKLS;
      o_TX_FORCE_ONES  <= loopback_sel == LOOP_SILENT || loopback_sel == LOOP_SILENT_CLKLS;
    end
  end

  // Divide-by-eight loop clock, held low unless a clockless loop is chosen
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET || !o_LOOP_DIV_CLOCK) begin
      loop_count <= 2'h0;
      o_DIV8_CLK <= 1'b0;
    end else begin
      loop_count <= loop_count + 2'h1;
      if (loop_count == 2'(LOOP_CLOCK_DIV / 2 - 1)) begin
        o_DIV8_CLK <= !o_DIV8_CLK;
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      o_OCTET_WINDOW_LIMIT <= '0;
      o_UNIT_WINDOW_LIMIT  <= '0;
    end else begin
      o_OCTET_WINDOW_LIMIT <= {scale_word[OCTET_HI_MSB:OCTET_HI_LSB], octet_lo};
      o_UNIT_WINDOW_LIMIT  <= UNIT_WINDOW;
    end
  end

  // Prescaler base step every TICK_DIV clocks
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + DIV_W'(1);
    end
  end

  assign base_step = div_count == DIV_W'(TICK_DIV - 1);

  // Prescaler period in base steps; narrow zero is the longest narrow period, wide word zero gives 65536
  always_comb begin
    if (wide_scaler_en) begin
      scale_period = WIDE_FULL_PERIOD - {1'b0, wide_scaler};
    end else if (scale_word[7:0] == 8'h00) begin
      scale_period = NARROW_ZERO_PERIOD;
    end else begin
      scale_period = 17'({scale_word[7:0], 4'h0});
    end
  end

  // Period changes take effect at once; a count already past a shorter limit wraps at the next base step
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      scale_count <= '0;
      tick        <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (base_step) begin
        if (scale_count >= scale_period - 17'h00001) begin
          scale_count <= '0;
          tick        <= 1'b1;
        end else begin
          scale_count <= scale_count + 17'h00001;
        end
      end
    end
  end

  // Timer bank
  for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_timer
    logic              run;
    logic [DATA_W-1:0] count;
    logic              allowed;

    assign allowed    = g < TMR_FIRST_JAPAN || japan_variant_en;
    assign exp_now[g] = run && allowed && tick && count == 16'hffff
                        && !i_TIMER_START[g] && !i_TIMER_STOP[g];

    always_ff @(posedge I_CLOCK) begin
      if (I_RESET) begin
        run   <= 1'b0;
        count <= '0;
      end else if (!allowed || i_TIMER_STOP[g]) begin
        run <= 1'b0;
      end else if (i_TIMER_START[g]) begin
        run   <= 1'b1;
        count <= period[g];
      end else if (run && tick) begin
        if (count == 16'hffff) begin
          run   <= PERIODIC_MASK[g];
          count <= period[g];
        end else begin
          count <= count + 16'h0001;
        end
      end
    end
  end

  // Expiry consequences
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      o_TIMER_EXPIRED <= '0;
      o_LINK_FAIL     <= 1'b0;
      o_PROVING_DONE  <= 1'b0;
      o_BUSY_REPEAT   <= 1'b0;
      o_TX_SCAN       <= 1'b0;
      o_INTERVAL_SEND <= '0;
    end else begin
      o_TIMER_EXPIRED <= exp_now;
      o_LINK_FAIL     <= |(exp_now & LINK_FAIL_MASK);
      o_PROVING_DONE  <= |(exp_now & PROVING_MASK);
      o_BUSY_REPEAT   <= exp_now[TMR_BUSY_REPEAT] && i_LOCAL_CONGESTED;
      o_TX_SCAN       <= exp_now[TMR_TX_POLL] || tx_demand || i_UNIT_RECEIVED;
      o_INTERVAL_SEND <= exp_now[NUM_TIMERS-1:TMR_FIRST_JAPAN];
    end
  end

  a_two_octet_addr: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    ##1 o_ADDR_TWO_OCTET == ($past(mode_word[MODE_EXT_ADDRESS_FORCE]) && $past(mode_word[MODE_EXT_ADDRESS_FIELD])))
    else $error("two-octet address flag does not follow mode bits");

  a_check_width_sel: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    $rose(mode_word[MODE_CHECK_WIDTH_SEL]) |=> o_CHECK_WIDTH_16)
    else $error("16-bit check not selected after width bit set");

  a_tx_check_off: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    mode_word[MODE_TX_CHECK_DISABLE] [*2] |-> !o_TX_CHECK_APPEND)
    else $error("check sequence appended while disabled");

  a_rx_strip_kept: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    mode_word[MODE_RX_CHECK_DISABLE] |=> o_RX_CHECK_STRIP && !o_RX_CHECK_VERIFY)
    else $error("check bits not stripped or still verified");

  a_silent_ones: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    loopback_sel[2] && loopback_sel[1] |=> o_TX_FORCE_ONES && o_LOOP_INTERNAL)
    else $error("silent loopback lets data reach the pin");

  a_loop_clock_rate: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    o_LOOP_DIV_CLOCK && $past(o_LOOP_DIV_CLOCK, 8) && $rose(o_DIV8_CLK)
      |-> !$past(o_DIV8_CLK, 4) && $past(o_DIV8_CLK, 5))
    else $error("loop clock period is not eight clocks");

  a_tick_spacing: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    tick |-> $past(base_step) ##1 !tick)
    else $error("prescaler tick faster than base step");

  a_expire_on_wrap: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    exp_now[0] |-> tick && g_timer[0].count == 16'hffff ##1 !g_timer[0].run)
    else $error("timer expired without wrapping or kept running");

  a_link_fail_ack: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    exp_now[7] |=> o_LINK_FAIL && o_TIMER_EXPIRED[7])
    else $error("acknowledge timeout without link failure");

  a_japan_gated: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    !japan_variant_en |=> o_INTERVAL_SEND == 4'h0)
    else $error("interval timer fired with variant disabled");

  a_scan_on_demand: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    i_WRITE && i_ADDR == OFS_CONTROL && i_WDATA[CTRL_TX_DEMAND] |-> ##2 o_TX_SCAN)
    else $error("transmit demand did not start a scan");

  a_status_sticky: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    exp_now[3] |=> expired_sticky[3])
    else $error("expiry lost from status");

endmodule

// [verification/ss7_param_host.sv]
// Host model: writes and reads the parameter block over the register port.
// Assumes one clock; strobes are one cycle, driven just after the rising edge.
module ss7_param_host
  import ss7_cfg_pkg::*;
(
  input  wire logic         i_clk,
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_wdata,
  output logic              o_write,
  output logic              o_read
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_addr = '0;
    o_wdata = '0;
    o_write = 1'b0;
    o_read = 1'b0;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] v;
    v = d;
    if (a == OFS_MODE) v[MODE_EXT_CONTROL_FORCE] = 1'b0;
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= v;
    o_write <= 1'b1;
    @(posedge i_clk);
    o_write <= 1'b0;
    // Released bus shows junk so stale values cannot pass
    o_addr <= ~a;
    o_wdata <= ~v;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge i_clk);
    o_addr <= a;
    o_read <= 1'b1;
    @(posedge i_clk);
    o_read <= 1'b0;
    o_addr <= ~a;
  endtask
endmodule

// [verification/ss7_link_config_timers_tb_top.sv]
// Self-checking bench for the link configuration and timer core.
// Assumes TICK_DIV of 2 and a narrow scaler of 1, so a tick is 32 clocks.
module ss7_link_config_timers_tb_top
  import ss7_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  I_CLOCK = 1'b0;
  logic                  I_RESET = 1'b1;
  logic [ADDR_W-1:0]     bus_addr;
  logic [DATA_W-1:0]     bus_wdata;
  logic                  bus_write;
  logic                  bus_read;
  logic [NUM_TIMERS-1:0] tmr_start = '0;
  logic [NUM_TIMERS-1:0] tmr_stop = '0;
  logic                  congested = 1'b1;
  logic                  unit_rx = 1'b0;
  logic [DATA_W-1:0]     o_RDATA;
  logic                  o_ADDR_TWO_OCTET, o_LEN_IN_BUFFER, o_RX_CHECK_STRIP, o_RX_CHECK_VERIFY;
  logic                  o_TX_CHECK_APPEND, o_CHECK_WIDTH_16, o_LOOP_INTERNAL, o_LOOP_DIV_CLOCK;
  logic                  o_TX_FORCE_ONES, o_DIV8_CLK, o_LINK_FAIL, o_PROVING_DONE, o_BUSY_REPEAT, o_TX_SCAN;
  logic [22:0]           o_OCTET_WINDOW_LIMIT;
  logic [7:0]            o_UNIT_WINDOW_LIMIT;
  logic [NUM_TIMERS-1:0] o_TIMER_EXPIRED;
  logic [3:0]            o_INTERVAL_SEND;
  logic [DATA_W-1:0]     exp_q[$];
  logic                  rd_pend = 1'b0;
  int                    mismatches = 0;
  int                    cmp_count = 0;
  int unsigned           seed;
  logic [DATA_W-1:0]     m;
  int                    highs, rises;
  logic                  prev;

  ss7_param_host host (.i_clk(I_CLOCK), .o_addr(bus_addr), .o_wdata(bus_wdata), .o_write(bus_write),
                       .o_read(bus_read));

  ss7_link_config_timers #(.TICK_DIV(2)) uut (
    .I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .i_ADDR(bus_addr), .i_WDATA(bus_wdata), .i_WRITE(bus_write),
    .i_READ(bus_read), .i_TIMER_START(tmr_start), .i_TIMER_STOP(tmr_stop), .i_LOCAL_CONGESTED(congested),
    .i_UNIT_RECEIVED(unit_rx), .o_RDATA(o_RDATA), .o_ADDR_TWO_OCTET(o_ADDR_TWO_OCTET),
    .o_LEN_IN_BUFFER(o_LEN_IN_BUFFER), .o_RX_CHECK_STRIP(o_RX_CHECK_STRIP), .o_RX_CHECK_VERIFY(o_RX_CHECK_VERIFY),
    .o_TX_CHECK_APPEND(o_TX_CHECK_APPEND), .o_CHECK_WIDTH_16(o_CHECK_WIDTH_16),
    .o_LOOP_INTERNAL(o_LOOP_INTERNAL), .o_LOOP_DIV_CLOCK(o_LOOP_DIV_CLOCK), .o_TX_FORCE_ONES(o_TX_FORCE_ONES),
    .o_DIV8_CLK(o_DIV8_CLK), .o_OCTET_WINDOW_LIMIT(o_OCTET_WINDOW_LIMIT),
    .o_UNIT_WINDOW_LIMIT(o_UNIT_WINDOW_LIMIT), .o_TIMER_EXPIRED(o_TIMER_EXPIRED), .o_LINK_FAIL(o_LINK_FAIL),
    .o_PROVING_DONE(o_PROVING_DONE), .o_BUSY_REPEAT(o_BUSY_REPEAT), .o_TX_SCAN(o_TX_SCAN),
    .o_INTERVAL_SEND(o_INTERVAL_SEND));

  always #5 I_CLOCK = ~I_CLOCK;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(negedge I_CLOCK) begin
    if (rd_pend) chk(o_RDATA, exp_q.pop_front());
    rd_pend = bus_read;
  end

  task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    host.rd(a);
    repeat (2) @(posedge I_CLOCK);
  endtask

  function automatic logic cls_out(input int idx);
    if (idx == 5) return o_BUSY_REPEAT;
    if (idx == 8) return o_TX_SCAN;
    if (idx > 8) return o_INTERVAL_SEND[idx-9];
    if (idx == 3 || idx == 4) return o_PROVING_DONE;
    return o_LINK_FAIL;
  endfunction

  // Two ticks from a period of 0xfffe; lo/hi bound the clocks to the event
  task automatic run_timer(input int idx, input int lo, input int hi, input logic fire);
    int n;
    logic seen_e, seen_c;
    n = 0;
    seen_e = 1'b0;
    seen_c = 1'b0;
    host.wr(idx < 9 ? OFS_TIMER_BASE + 8'(2 * idx) : OFS_JAPAN_BASE + 8'(2 * (idx - 9)), 16'hfffe);
    @(posedge I_CLOCK);
    tmr_start[idx] <= 1'b1;
    @(posedge I_CLOCK);
    tmr_start <= '0;
    while (!seen_c && n < hi + 8) begin
      @(negedge I_CLOCK);
      n++;
      if (o_TIMER_EXPIRED[idx] === 1'b1) seen_e = 1'b1;
      if (cls_out(idx) === 1'b1) seen_c = 1'b1;
    end
    chk(seen_c, fire);
    if (fire) begin
      chk(seen_e, 1'b1);
      chk(n > lo && n <= hi, 1'b1);
    end
    @(posedge I_CLOCK);
    tmr_stop <= '1;
    @(posedge I_CLOCK);
    tmr_stop <= '0;
    if (fire && !seen_c) stop_test();
  endtask

  task automatic wait_scan;
    int n;
    n = 0;
    do begin
      @(negedge I_CLOCK);
      n++;
    end while (o_TX_SCAN !== 1'b1 && n < 8);
    chk(o_TX_SCAN, 1'b1);
    if (o_TX_SCAN !== 1'b1) stop_test();
  endtask

  initial begin
    seed = $urandom(32'hdfe12ba3);
    repeat (12) @(posedge I_CLOCK);
    I_RESET <= 1'b0;
    @(posedge I_CLOCK);
    @(negedge I_CLOCK);
    chk(o_UNIT_WINDOW_LIMIT, 8'h80);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      m = 16'($urandom) & 16'h07f8;
      m[2:0] = 3'(i % 8);
      host.wr(OFS_MODE, m);
      repeat (3) @(posedge I_CLOCK);
      @(negedge I_CLOCK);
      chk({o_ADDR_TWO_OCTET, o_LEN_IN_BUFFER, o_RX_CHECK_STRIP, o_RX_CHECK_VERIFY, o_TX_CHECK_APPEND,
           o_CHECK_WIDTH_16, o_LOOP_INTERNAL, o_LOOP_DIV_CLOCK, o_TX_FORCE_ONES},
          {m[9] & m[6], m[8], 1'b1, ~m[5], ~m[4], m[3], m[2], m[2] & m[0], m[2] & m[1]});
      read_chk(OFS_MODE, m & 16'hfbff);
    end
    read_chk(8'h40, 16'h0000);
    read_chk(8'h01, 16'h0000);
    $display("test mode word done");
    host.wr(OFS_MODE, 16'h0005);
    repeat (4) @(posedge I_CLOCK);
    highs = 0;
    rises = 0;
    @(negedge I_CLOCK);
    prev = o_DIV8_CLK;
    for (int i = 0; i < 16; i++) begin
      @(negedge I_CLOCK);
      if (o_DIV8_CLK === 1'b1) highs++;
      if (o_DIV8_CLK === 1'b1 && prev === 1'b0) rises++;
      prev = o_DIV8_CLK;
    end
    chk(highs, 8);
    chk(rises, 2);
    $display("test divided clock done");
    host.wr(OFS_SCALE_WORD, 16'h7f01);
    host.wr(OFS_OCTET_LO, 16'h1234);
    repeat (3) @(posedge I_CLOCK);
    @(negedge I_CLOCK);
    chk(o_OCTET_WINDOW_LIMIT, {7'h7f, 16'h1234});
    read_chk(OFS_SCALE_WORD, 16'h7f01);
    host.wr(OFS_CONTROL, 16'h0000);
    run_timer(9, 33, 65, 1'b0);
    host.wr(OFS_CONTROL, 16'h0002);
    for (int t = 0; t < NUM_TIMERS; t++) run_timer(t, 33, 65, 1'b1);
    congested <= 1'b0;
    run_timer(5, 33, 65, 1'b0);
    read_chk(OFS_STATUS, 16'h1fff);
    host.wr(OFS_STATUS, 16'h1fff);
    read_chk(OFS_STATUS, 16'h0000);
    $display("test narrow timers done");
    // Zero narrow scaler is the longest narrow tick, 4112 steps
    host.wr(OFS_SCALE_WORD, 16'h7f00);
    run_timer(0, 8225, 16449, 1'b1);
    $display("test zero scaler done");
    host.wr(OFS_WIDE_SCALER, 16'hffe0);
    host.wr(OFS_CONTROL, 16'h0003);
    run_timer(7, 65, 129, 1'b1);
    $display("test wide scaler done");
    host.wr(OFS_CONTROL, 16'h0006);
    wait_scan();
    read_chk(OFS_CONTROL, 16'h0002);
    @(posedge I_CLOCK);
    unit_rx <= 1'b1;
    @(posedge I_CLOCK);
    unit_rx <= 1'b0;
    wait_scan();
    $display("test transmit scan done");
    stop_test();
  end
endmodule
